// ### rtl/cwd_wave_top.sv
// register file and output logic of two complementary wave generators
//
// Notes on behaviour
// (RULE1) falling dead-band count, six bits, own register
// (RULE2) nonzero count N delays N to N+1 periods
// (RULE3) zero count bypasses dead-band entirely
// (RULE4) upper two dead-band bits read zero
// (RULE5) all resets clear the falling count
// (RULE6) polarity bits 3..0, input state bit 5
// (RULE7) override data 7..4, steering enables 3..0
// (RULE8) shutdown status, restart, two state fields
// (RULE9) five shutdown source enables, rest zero
// (RULE10) gen2/gen1 flags bits 7/6, enables alike
// (RULE11) rising count separate six-bit low field
// (RULE12) steered outputs carry data with polarity
// (RULE13) shutdown codes: high, low, float, inactive
// (RULE14) shutdown holds until next data rising edge
// (RULE15) counter restarts each edge, counts generator clock
// (RULE16) both instances identical apart from placement
`timescale 1ns/10ps
module cwd_wave_top
  import cwd_pkg::*;
#(
  parameter int DIV = DIV_DEFAULT
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire logic [NUM_GEN-1:0][NUM_SRC-1:0] genSrc,
  input wire logic [NUM_GEN-1:0][NUM_SHUT-1:0] shutSrc,
  output logic [NUM_GEN-1:0][3:0] waveOut,
  output logic [NUM_GEN-1:0][3:0] waveOutEn,
  output logic irq
);
  // ==========================================================
  // elaboration check
  if (DIV < 2) begin : g_bad_div
    $error("generator divider must be at least two");
  end

  // ==========================================================
  // reset release
  logic rstMeta; // first synchroniser stage
  logic rstn;    // released reset for the block
  // two flops so release is clean against clk
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rstMeta <= 1'b0;
      rstn <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstn <= rstMeta;
    end
  end

  // ==========================================================
  // decode helper
  // true when the address hits register off of instance gi
  function automatic logic regHit(input logic [7:0] a, input int gi,
                                  input logic [7:0] off);
    logic [7:0] base;
    base = 8'(gi * int'(GEN_STRIDE));
    return a == (base + off);
  endfunction : regHit

  // ==========================================================
  // register state, one entry per instance except the shared divTick
  logic [7:0] con0 [NUM_GEN];   // enable, load, mode
  logic [3:0] pol [NUM_GEN];    // output polarities
  logic clkSel [NUM_GEN];       // 1 = divided generator clock
  logic [3:0] dat [NUM_GEN];    // data source select
  logic [7:0] steer [NUM_GEN];  // override and steering bits
  logic [7:0] as0 [NUM_GEN];    // shutdown control
  logic [4:0] as1 [NUM_GEN];    // shutdown source enables
  logic [5:0] rising_deadband_count [NUM_GEN];    // rising dead-band count
  logic [5:0] dbf [NUM_GEN];    // falling dead-band count
  logic dataQ [NUM_GEN];        // selected data input, sampled
  logic shutEvt [NUM_GEN];      // shutdown newly entered
  logic [NUM_GEN-1:0] irqFlag;  // sticky interrupt flags
  logic [NUM_GEN-1:0] irqEn;    // interrupt enables
  logic [3:0] next_out [NUM_GEN]; // output levels to register
  logic [3:0] next_oe [NUM_GEN];  // output enables to register
  logic divTick;                // slow generator clock enable

  // ==========================================================
  // slow generator clock
  cwd_clk_div #(
    .DIV(DIV)
  ) u_div (
    .clk(clk),
    .rstn(rstn),
    .tick(divTick)
  );

  // ==========================================================
  // per-instance logic
  // (RULE16) one body serves every instance
  for (genvar g = 0; g < NUM_GEN; g++) begin : g_gen
    logic dataPrev;    // data one cycle back
    logic dataRise;    // data rising edge
    logic srcHit;      // an enabled shutdown source is active
    logic shutHold;    // outputs kept in shutdown state
    logic [7:0] strAct; // steering in use
    logic [5:0] dbrAct; // rising count in use
    logic [5:0] dbfAct; // falling count in use
    logic genTick;     // dead-band clock enable
    logic [2:0] mode;  // operating mode
    logic inShut;      // shutdown state applies
    cwd_db_if #(.CW(DB_W)) riseIf ();
    cwd_db_if #(.CW(DB_W)) fallIf ();

    assign mode = con0[g][2:0];
    assign srcHit = |(as1[g] & shutSrc[g]);
    assign dataRise = dataQ[g] && !dataPrev;
    assign inShut = as0[g][AS0_SHUT] || shutHold;
    assign shutEvt[g] = srcHit && !as0[g][AS0_SHUT];
    // (RULE15) counts only the selected generator clock
    assign genTick = clkSel[g] ? divTick : 1'b1;

    // sample the selected source; reserved codes read low
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        dataQ[g] <= 1'b0;
        dataPrev <= 1'b0;
      end else begin
        dataQ[g] <= genSrc[g][dat[g]] && (dat[g] < 4'hE);
        dataPrev <= dataQ[g];
      end
    end

    // plain control registers
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        pol[g] <= '0;
        clkSel[g] <= 1'b0;
        dat[g] <= '0;
        steer[g] <= RST_ZERO;
        as1[g] <= '0;
        rising_deadband_count[g] <= '0;
        // (RULE5) every reset clears the count
        dbf[g] <= '0;
      end else if (regWr) begin
        // (RULE6) polarity selects in bits 3..0
        if (regHit(regAddr, g, OFF_CON1)) pol[g] <= regWdata[3:0];
        if (regHit(regAddr, g, OFF_CLKCON)) clkSel[g] <= regWdata[0];
        if (regHit(regAddr, g, OFF_DAT)) dat[g] <= regWdata[3:0];
        // (RULE7) override data high, enables low
        if (regHit(regAddr, g, OFF_STR)) steer[g] <= regWdata;
        // (RULE9) five source enables only
        if (regHit(regAddr, g, OFF_AS1)) as1[g] <= regWdata[4:0];
        // (RULE11) rising count in its own register
        if (regHit(regAddr, g, OFF_DBR)) rising_deadband_count[g] <= regWdata[5:0];
        // (RULE1) falling count bits 5..0
        if (regHit(regAddr, g, OFF_DBF)) dbf[g] <= regWdata[5:0];
      end
    end

    // enable, mode and load request; hardware clears load
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        con0[g] <= RST_ZERO;
      end else if (regWr && regHit(regAddr, g, OFF_CON0)) begin
        con0[g] <= regWdata & MASK_CON0;
      end else if (con0[g][CON0_LD] && con0[g][CON0_EN] && dataRise) begin
        con0[g][CON0_LD] <= 1'b0;
      end
    end

    // double buffer: live while disabled, else at loaded edge
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        strAct <= RST_ZERO;
        dbrAct <= '0;
        dbfAct <= '0;
      end else if (!con0[g][CON0_EN]
                   || (con0[g][CON0_LD] && dataRise)) begin
        strAct <= steer[g];
        dbrAct <= rising_deadband_count[g];
        dbfAct <= dbf[g];
      end
    end

    // shutdown status: source set wins over any clear
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        as0[g] <= RST_AS0;
      end else begin
        if (regWr && regHit(regAddr, g, OFF_AS0)) begin
          // (RULE8) status, restart and both state fields
          as0[g] <= regWdata & MASK_AS0;
        end else if (as0[g][AS0_REN] && !srcHit) begin
          // auto-restart drops status once sources go quiet
          as0[g][AS0_SHUT] <= 1'b0;
        end
        if (srcHit) begin
          as0[g][AS0_SHUT] <= 1'b1;
        end
      end
    end

    // (RULE14) hold shutdown until next data rising edge
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        shutHold <= 1'b0;
      end else if (as0[g][AS0_SHUT]) begin
        shutHold <= 1'b1;
      end else if (dataRise) begin
        shutHold <= 1'b0;
      end
    end

    // rising dead-band on the primary phase
    assign riseIf.tick = genTick;
    assign riseIf.level = dataQ[g];
    assign riseIf.count = dbrAct;
    // falling dead-band on the complementary phase
    assign fallIf.tick = genTick;
    assign fallIf.level = !dataQ[g];
    assign fallIf.count = dbfAct;

    cwd_edge_delay u_rise (
      .clk(clk),
      .rstn(rstn),
      .db(riseIf)
    );

    // (RULE15) complement held off until count expires
    cwd_edge_delay u_fall (
      .clk(clk),
      .rstn(rstn),
      .db(fallIf)
    );

    // output selection for the four pins
    always_comb begin
      logic [1:0] code;
      logic [3:0] base;
      code = 2'h0;
      base = 4'h0;
      for (int i = 0; i < 4; i++) begin
        if (mode == MODE_STEER || mode == MODE_SYNC_STEER) begin
          // (RULE12) steered pins carry data with polarity
          if ((mode == MODE_STEER) ? steer[g][i] : strAct[i]) begin
            base[i] = dataQ[g] ^ pol[g][i];
          end else begin
            base[i] = (mode == MODE_STEER) ? steer[g][i+4] : strAct[i+4];
          end
        end else begin
          // bridge modes: a/c primary, b/d complementary
          base[i] = ((i % 2 == 0) ? riseIf.delayed : fallIf.delayed)
                    ^ pol[g][i];
        end
      end
      next_oe[g] = 4'hF;
      next_out[g] = base;
      if (!con0[g][CON0_EN]) begin
        // disabled: inactive level, polarity applied
        next_out[g] = pol[g];
      end
      if (inShut) begin
        for (int i = 0; i < 4; i++) begin
          // b/d use the upper field, a/c the lower
          code = (i % 2 == 1) ? as0[g][AS0_BD_HI -: 2]
                              : as0[g][AS0_AC_HI -: 2];
          // (RULE13) pick level or float per code
          unique case (code)
            SD_HIGH: next_out[g][i] = 1'b1;
            SD_LOW: next_out[g][i] = 1'b0;
            SD_TRI: next_oe[g][i] = 1'b0;
            default: next_out[g][i] = pol[g][i];
          endcase
        end
      end
    end
  end

  // ==========================================================
  // interrupt flags and enables
  // (RULE10) flag per instance, set beats write-one clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irqFlag <= '0;
      irqEn <= '0;
    end else begin
      for (int g = 0; g < NUM_GEN; g++) begin
        if (shutEvt[g]) begin
          irqFlag[g] <= 1'b1;
        end else if (regWr && regAddr == OFF_IRQ_FLAGS
                     && regWdata[IRQ_BIT_BASE + g]) begin
          irqFlag[g] <= 1'b0;
        end
        if (regWr && regAddr == OFF_IRQ_EN) begin
          irqEn[g] <= regWdata[IRQ_BIT_BASE + g];
        end
      end
    end
  end

  // ==========================================================
  // registered outputs
  // pins and interrupt come straight from flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      waveOut <= '0;
      waveOutEn <= '0;
      irq <= 1'b0;
    end else begin
      for (int g = 0; g < NUM_GEN; g++) begin
        waveOut[g] <= next_out[g];
        waveOutEn[g] <= next_oe[g];
      end
      irq <= |(irqFlag & irqEn);
    end
  end

  // ==========================================================
  // read path
  logic [7:0] next_rdata; // value for the read answer
  // unmapped addresses answer zero
  always_comb begin
    next_rdata = 8'h00;
    for (int g = 0; g < NUM_GEN; g++) begin
      if (regHit(regAddr, g, OFF_CON0)) next_rdata = con0[g];
      // (RULE6) input state shows in bit 5
      if (regHit(regAddr, g, OFF_CON1)) begin
        next_rdata = {2'h0, dataQ[g], 1'b0, pol[g]};
      end
      if (regHit(regAddr, g, OFF_CLKCON)) next_rdata = {7'h00, clkSel[g]};
      if (regHit(regAddr, g, OFF_DAT)) next_rdata = {4'h0, dat[g]};
      if (regHit(regAddr, g, OFF_STR)) next_rdata = steer[g];
      // (RULE8) low two bits read zero
      if (regHit(regAddr, g, OFF_AS0)) next_rdata = as0[g] & MASK_AS0;
      if (regHit(regAddr, g, OFF_AS1)) next_rdata = {3'h0, as1[g]};
      if (regHit(regAddr, g, OFF_DBR)) next_rdata = {2'h0, rising_deadband_count[g]};
      // (RULE4) bits 7..6 always zero
      if (regHit(regAddr, g, OFF_DBF)) next_rdata = {2'h0, dbf[g]};
    end
    if (regAddr == OFF_IRQ_FLAGS) begin
      next_rdata = {irqFlag, 6'h00};
    end
    if (regAddr == OFF_IRQ_EN) begin
      next_rdata = {irqEn, 6'h00};
    end
  end

  // data stand only in the cycle after the strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      regRdata <= 8'h00;
    end else begin
      regRdata <= regRd ? next_rdata : 8'h00;
    end
  end
endmodule : cwd_wave_top

// ### common/cwd_pkg.sv
// shared constants for the complementary wave generator register block
package cwd_pkg;
  // ==========================================================
  // instance layout
  localparam int NUM_GEN = 2;          // generator instances
  localparam int NUM_SRC = 16;         // data-source select codes
  localparam int NUM_SHUT = 5;         // shutdown sources per instance
  localparam int DB_W = 6;             // dead-band count width
  localparam int DIV_DEFAULT = 8;      // slow generator clock divide
  // ==========================================================
  // register offsets (byte addresses, 8-bit bus)
  localparam logic [7:0] GEN_STRIDE = 8'h10;
  localparam logic [7:0] OFF_CON0 = 8'h00;
  localparam logic [7:0] OFF_CON1 = 8'h01;
  localparam logic [7:0] OFF_CLKCON = 8'h02;
  localparam logic [7:0] OFF_DAT = 8'h03;
  localparam logic [7:0] OFF_STR = 8'h04;
  localparam logic [7:0] OFF_AS0 = 8'h05;
  localparam logic [7:0] OFF_AS1 = 8'h06;
  localparam logic [7:0] OFF_DBR = 8'h07;
  localparam logic [7:0] OFF_DBF = 8'h08;
  localparam logic [7:0] OFF_IRQ_FLAGS = 8'h20;
  localparam logic [7:0] OFF_IRQ_EN = 8'h21;
  // ==========================================================
  // field positions
  localparam int CON0_EN = 7;          // generator enable
  localparam int CON0_LD = 6;          // buffer load request
  localparam int CON1_IN = 5;          // input state, read only
  localparam int AS0_SHUT = 7;         // shutdown status
  localparam int AS0_REN = 6;          // auto-restart enable
  localparam int AS0_BD_HI = 5;        // shutdown state b/d field
  localparam int AS0_AC_HI = 3;        // shutdown state a/c field
  localparam int IRQ_BIT_BASE = 6;     // gen1 flag bit, gen2 is next
  localparam logic [2:0] MODE_STEER = 3'h0;
  localparam logic [2:0] MODE_SYNC_STEER = 3'h1;
  // ==========================================================
  // writable masks and reset values
  localparam logic [7:0] MASK_CON0 = 8'hC7;
  localparam logic [7:0] MASK_POL = 8'h0F;
  localparam logic [7:0] MASK_CLKCON = 8'h01;
  localparam logic [7:0] MASK_DAT = 8'h0F;
  localparam logic [7:0] MASK_AS0 = 8'hFC;
  localparam logic [7:0] MASK_AS1 = 8'h1F;
  localparam logic [7:0] MASK_DB = 8'h3F;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_AS0 = 8'h14;
  // shutdown pin codes
  localparam logic [1:0] SD_HIGH = 2'h3;
  localparam logic [1:0] SD_LOW = 2'h2;
  localparam logic [1:0] SD_TRI = 2'h1;
endpackage : cwd_pkg

// ### common/cwd_db_if.sv
// link between a generator and one dead-band edge delay
`timescale 1ns/10ps
interface cwd_db_if #(
  parameter int CW = 6
);
  logic tick;          // generator clock enable
  logic level;         // undelayed level
  logic [CW-1:0] count; // programmed delay in ticks
  logic delayed;       // level with rising edge delayed
  modport gen (output tick, output level, output count, input delayed);
  modport dly (input tick, input level, input count, output delayed);
endinterface : cwd_db_if

// ### rtl/cwd_clk_div.sv
// divider giving the slow generator clock as an enable pulse
`timescale 1ns/10ps
module cwd_clk_div #(
  parameter int DIV = 8
) (
  input wire logic clk,
  input wire logic rstn,
  output logic tick
);
  // ==========================================================
  // elaboration check
  if (DIV < 2) begin : g_bad
    $error("divider must be at least two");
  end
  logic [$clog2(DIV)-1:0] cnt; // cycles since last pulse
  // pulse once every DIV cycles
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= '0;
      tick <= 1'b0;
    end else if (cnt == $clog2(DIV)'(DIV - 1)) begin
      cnt <= '0;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule : cwd_clk_div

// ### rtl/cwd_edge_delay.sv
// dead-band element: delays the rising edge of a level by N+1 ticks, none when N is zero
`timescale 1ns/10ps
module cwd_edge_delay (
  input wire logic clk,
  input wire logic rstn,
  cwd_db_if.dly db
);
  localparam int CW = $bits(db.count);
  logic [CW-1:0] remain; // ticks still to wait
  logic busy;            // a delay is running
  // ==========================================================
  // restart on each rising edge, release after the count
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      remain <= '0;
      busy <= 1'b0;
      db.delayed <= 1'b0;
    end else if (!db.level) begin
      // falling level passes at once and aborts any wait
      busy <= 1'b0;
      db.delayed <= 1'b0;
    end else if (!db.delayed && !busy) begin
      // (RULE3) zero count bypasses
      if (db.count == '0) begin
        db.delayed <= 1'b1;
      end else begin
        remain <= db.count;
        busy <= 1'b1;
      end
    end else if (busy && db.tick) begin
      // (RULE2) n+1 ticks: unknown tick phase then gives n..n+1 periods
      if (remain == '0) begin
        busy <= 1'b0;
        db.delayed <= 1'b1;
      end else begin
        remain <= remain - 1'b1;
      end
    end
  end
endmodule : cwd_edge_delay

// ### tb/cwd_wave_checker.sv
// read-side assertions on the register port of the wave generator top
`timescale 1ns/10ps
module cwd_wave_checker
  import cwd_pkg::*;
#(
  parameter int DIV = DIV_DEFAULT
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  input wire logic [NUM_GEN-1:0][NUM_SRC-1:0] genSrc,
  input wire logic [NUM_GEN-1:0][NUM_SHUT-1:0] shutSrc,
  input wire logic [NUM_GEN-1:0][3:0] waveOut,
  input wire logic [NUM_GEN-1:0][3:0] waveOutEn,
  input wire logic irq
);
  // ==========================================================
  // clocking, all checks sleep while reset is low
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // read of one offset in either generator instance
  sequence rdGen(logic [3:0] o);
    regRd && regAddr[7:5] == 3'h0 && regAddr[3:0] == o;
  endsequence
  // read of a global address
  sequence rdAt(logic [7:0] a);
    regRd && regAddr == a;
  endsequence
  // ==========================================================
  // read data only in the cycle after a strobe
  idle_rdata_a: assert property (!regRd |=> regRdata == 8'h00)
    else $error("read data not zero outside read slot");
  fall_upper_zero_a: assert property (rdGen(OFF_DBF[3:0]) |=> regRdata[7:6] == 2'h0)
    else $error("falling count upper bits not zero");
  rise_upper_zero_a: assert property (
    rdGen(OFF_DBR[3:0]) ##1 1'b1 |-> regRdata[7:6] == 2'h0)
    else $error("rising count upper bits not zero");
  shut_low_zero_a: assert property (rdGen(OFF_AS0[3:0]) |=> regRdata[1:0] == 2'h0)
    else $error("shutdown control low bits not zero");
  src_upper_zero_a: assert property (rdGen(OFF_AS1[3:0]) |=> regRdata[7:5] == 3'h0)
    else $error("source enable upper bits not zero");
  pol_spare_zero_a: assert property (
    rdGen(OFF_CON1[3:0]) |=> !regRdata[7] && !regRdata[6] && !regRdata[4])
    else $error("polarity register spare bits not zero");
  flag_spare_zero_a: assert property (rdAt(OFF_IRQ_FLAGS) |=> regRdata[5:0] == 6'h00)
    else $error("flag register spare bits not zero");
  unmapped_zero_a: assert property (
    regRd && regAddr > OFF_IRQ_EN |=> regRdata == 8'h00)
    else $error("unmapped read not zero");
  input_state_a: assert property (
    rdGen(OFF_CON1[3:0]) ##0 (regAddr[4] == 1'b0 && $past(genSrc[0][0]) == genSrc[0][0]
    && genSrc[0][0] == 1'b0) |=> !regRdata[5])
    else $error("input state bit set with low data");
endmodule : cwd_wave_checker

bind cwd_wave_top cwd_wave_checker #(.DIV(DIV)) i_chk (.clk(clk), .resetn(resetn),
  .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
  .regRdata(regRdata), .genSrc(genSrc), .shutSrc(shutSrc), .waveOut(waveOut),
  .waveOutEn(waveOutEn), .irq(irq));

// ### tb/cwd_gate_model.sv
// gate-driver model: resolves one generator's four pins
`timescale 1ns/10ps
module cwd_gate_model (
  input wire logic clk,
  input wire logic [3:0] drv,
  input wire logic [3:0] drvEn,
  output logic [3:0] pin
);
  logic [3:0] last = 4'h0; // level seen on the pins one cycle ago
  // ==========================================================
  // a floating pin toggles, so a stale level never passes a check
  always_ff @(posedge clk) begin
    last <= pin;
  end
  assign pin = (drv & drvEn) | (~last & ~drvEn);
endmodule : cwd_gate_model

// ### tb/test_complementary_wave_deadband_regs.sv
// self-checking bench for the wave generator register block
`timescale 1ns/10ps
module test_complementary_wave_deadband_regs
  import cwd_pkg::*;
;
  localparam int DIV_T = 4; // short slow-clock divide
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata;
  logic regWr = 1'b0, regRd = 1'b0, irq;
  logic [NUM_GEN-1:0][NUM_SRC-1:0] genSrc = '0;
  logic [NUM_GEN-1:0][NUM_SHUT-1:0] shutSrc = '0;
  logic [NUM_GEN-1:0][3:0] waveOut, waveOutEn, pin;
  int n_errors = 0, cmp_count = 0, seed = 32'hc1e0;
  int ta, tb, ta0, tb0, lo, hi;
  logic [7:0] v, b, offs [7], masks [7];
  // ==========================================================
  // clock, dut and far-side drivers
  initial begin
    forever #2.5 clk = ~clk;
  end
  cwd_wave_top #(.DIV(DIV_T)) i_dut (.clk(clk), .resetn(resetn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .genSrc(genSrc), .shutSrc(shutSrc), .waveOut(waveOut), .waveOutEn(waveOutEn), .irq(irq));
  for (genvar g = 0; g < NUM_GEN; g++) begin : g_pins
    cwd_gate_model i_gate (.clk(clk), .drv(waveOut[g]), .drvEn(waveOutEn[g]), .pin(pin[g]));
  end
  // ==========================================================
  // compare, bus and end-of-run tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    chk(regRdata, exp);
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // cycles until output idx of generator 0 goes high, bounded
  task automatic meas(input int idx, output int t);
    t = 0;
    while (waveOut[0][idx] !== 1'b1 && t < 300) begin
      @(posedge clk);
      t++;
    end
  endtask : meas
  // steered level: data with polarity, else override bit
  function automatic logic [3:0] steer_exp(logic [7:0] s, logic [3:0] p, logic d);
    return (s[3:0] & ({4{d}} ^ p)) | (~s[3:0] & s[7:4]);
  endfunction : steer_exp
  task automatic complete_run;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run
  // watchdog on a hung run
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    complete_run();
  end
  // ==========================================================
  // main sequence
  initial begin
    offs = '{OFF_CON1, OFF_CLKCON, OFF_DAT, OFF_STR, OFF_AS1, OFF_DBR, OFF_DBF};
    masks = '{MASK_POL, MASK_CLKCON, MASK_DAT, 8'hFF, MASK_AS1, MASK_DB, MASK_DB};
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    genSrc <= $random(seed) & 32'hFFFEFFFE;
    cyc(6);
    // reset values, writable bits, both instances alike
    for (int g = 0; g < NUM_GEN; g++) begin
      b = GEN_STRIDE * g;
      for (int k = 0; k < 7; k++) begin
        v = $random(seed);
        rd(b + offs[k], 8'h00);
        wr(b + offs[k], v);
        rd(b + offs[k], v & masks[k]);
        wr(b + offs[k], 8'h00);
      end
      rd(b + OFF_AS0, RST_AS0);
      wr(b + OFF_AS0, 8'h7F);
      rd(b + OFF_AS0, 8'h7C);
      wr(b + OFF_AS0, RST_AS0);
      genSrc[g][0] <= 1'b1;
      cyc(3);
      rd(b + OFF_CON1, 8'h20);
      genSrc[g][0] <= 1'b0;
      // both steering modes, random codes and data
      for (int m = 0; m < 2; m++) begin
        repeat (4) begin
          v = $random(seed);
          wr(b + OFF_CON0, {5'h00, m[2:0]});
          wr(b + OFF_STR, v);
          wr(b + OFF_CON1, {4'h0, v[6:3]});
          wr(b + OFF_CON0, {5'h10, m[2:0]});
          genSrc[g][0] <= v[0];
          cyc(4);
          chk({4'h0, pin[g]}, {4'h0, steer_exp(v, v[6:3], v[0])});
        end
      end
      wr(b + OFF_CON1, 8'h00);
    end
    rd(8'h30, 8'h00);
    wr(8'h30, 8'hFF);
    rd(8'h30, 8'h00);
    // dead-band: fast clock counts, then one slow-clock count
    genSrc[0][0] <= 1'b0;
    wr(OFF_CON0, 8'h84);
    for (int k = 0; k < 6; k++) begin
      v = k == 0 ? 8'h00 : (k == 1 ? 8'h01 : (k == 2 ? 8'h02 : (k == 3 ? 8'h3F : 8'h03)));
      wr(OFF_CLKCON, {7'h00, k == 5});
      wr(OFF_DBF, v);
      // counts are buffered while enabled: load them at the next rise
      wr(OFF_CON0, 8'hC4);
      cyc(400);
      genSrc[0][0] <= 1'b1;
      meas(0, ta);
      cyc(400);
      genSrc[0][0] <= 1'b0;
      meas(1, tb);
      cyc(2);
      if (k == 0) begin
        ta0 = ta;
        tb0 = tb;
        chk({7'h0, ta == tb}, 8'h01);
      end else begin
        lo = k == 5 ? v * DIV_T : v;
        hi = (v + 1) * (k == 5 ? DIV_T : 1);
        chk({7'h0, ta == ta0}, 8'h01);
        chk({7'h0, tb - tb0 >= lo && tb - tb0 <= hi}, 8'h01);
      end
    end
    wr(OFF_CLKCON, 8'h00);
    // random levels on sources that stay masked off
    shutSrc <= $random(seed) & 10'h37B;
    // shutdown entry, flag, mask, clear, float, hold until data rise
    for (int g = 0; g < NUM_GEN; g++) begin
      b = GEN_STRIDE * g;
      genSrc[g][0] <= 1'b0;
      wr(b + OFF_CON0, 8'h80 | {5'h00, MODE_STEER});
      wr(b + OFF_STR, 8'h00);
      wr(b + OFF_AS1, 8'h04);
      wr(b + OFF_AS0, 8'h38);
      wr(OFF_IRQ_EN, 8'h40 << g);
      shutSrc[g][2] <= 1'b1;
      cyc(4);
      chk({4'h0, waveOut[g]}, 8'h0A);
      chk({7'h0, irq}, 8'h01);
      rd(b + OFF_AS0, 8'hB8);
      rd(OFF_IRQ_FLAGS, 8'h40 << g);
      wr(OFF_IRQ_EN, 8'h00);
      cyc(3);
      chk({7'h0, irq}, 8'h00);
      wr(OFF_IRQ_FLAGS, 8'h40 << g);
      rd(OFF_IRQ_FLAGS, 8'h00);
      wr(b + OFF_AS0, 8'h94);
      cyc(4);
      chk({4'h0, waveOutEn[g]}, 8'h00);
      shutSrc[g][2] <= 1'b0;
      wr(b + OFF_AS0, 8'h3C);
      cyc(10);
      chk({4'h0, waveOut[g]}, 8'h0F);
      genSrc[g][0] <= 1'b1;
      cyc(4);
      chk({waveOutEn[g], waveOut[g]}, 8'hF0);
      wr(b + OFF_AS1, 8'h00);
    end
    // second reset in mid-run clears the falling count
    wr(OFF_DBF, 8'h2A);
    rd(OFF_DBF, 8'h2A);
    resetn <= 1'b0;
    cyc(3);
    resetn <= 1'b1;
    cyc(6);
    rd(OFF_DBF, 8'h00);
    complete_run();
  end
endmodule : test_complementary_wave_deadband_regs
